/* File: hdl/cpp_pkg.sv */
/*
  Shared constants and carriers for the charger and power-path controller.
  Assumes a single device clock and an APB master with 32-bit data.
*/
package cpp_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_EVT = 8'h08;

  // Control register fields
  localparam int B_ALLOW = 0;
  localparam int B_RUN = 1;
  localparam int B_SUSP = 2;
  localparam int B_LIM_HI = 3;
  localparam int B_LIM_WIDE = 4;
  localparam int B_RATE_LO = 5;
  localparam int B_RATE_HI = 6;
  localparam int B_FIN_BLK = 7;
  localparam int B_SLEEP = 8;
  localparam int B_ID_LO = 9;
  localparam int CTRL_W = 11;
  localparam logic [CTRL_W-1:0] CTRL_RST = 11'h003;

  // Event register bits, write one to clear
  localparam int E_REMOVED = 0;
  localparam int E_TERM = 1;
  localparam int E_FAULT_SC = 2;

  // Charge references in tenths of a percent of the full fast reference
  localparam logic [9:0] REF_PRE = 10'h064;
  localparam logic [9:0] REF_25 = 10'h0FA;
  localparam logic [9:0] REF_50 = 10'h1F4;
  localparam logic [9:0] REF_75 = 10'h2EE;
  localparam logic [9:0] REF_100 = 10'h3E8;
  localparam logic [9:0] TERM_DIV = 10'h00A;

  // USB input limit codes
  localparam logic [1:0] LIM_100MA = 2'h0;
  localparam logic [1:0] LIM_500MA = 2'h1;
  localparam logic [1:0] LIM_FULL = 2'h2;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_PRE,
    PH_FAST,
    PH_REG,
    PH_DONE
  } cpp_phase_t;

  // Comparator and loop flags from the analog side
  typedef struct packed {
    logic ac_ok;
    logic usb_ok;
    logic out_short;
    logic bat_short;
    logic sup_need;
    logic dppm_low;
    logic chg_zero;
    logic nobat;
    logic lowv;
    logic below_rch;
    logic above_pre;
    logic cv_loop;
    logic taper;
    logic hot;
  } cpp_cmp_t;

  // Switch and pullup drive
  typedef struct packed {
    logic ac_on;
    logic usb_on;
    logic bat_on;
    logic in_pullup;
    logic bat_pullup;
    logic discharge;
  } cpp_sw_t;

endpackage

/* File: hdl/cpp_ctrl.sv */
/*
  Charger phase sequencer and power-path switch control with an APB register file.
  Assumes comparator flags arrive asynchronously from analog circuitry and the
  pack-removal comparator is already deglitched.
*/
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps

module cpp_ctrl #(
  parameter int STARTUP_CYCLES = 1024
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog flags
  input wire cpp_pkg::cpp_cmp_t cmp_in,
  // Power path drive
  output cpp_pkg::cpp_sw_t sw,
  output logic [1:0] usb_limit,
  // Charger drive
  output logic chg_enable,
  output logic [9:0] chg_ref,
  output logic [9:0] term_ref,
  output logic thermal_fold,
  output logic chg_reduce,
  output logic timer_start,
  output logic [2:0] phase,
  // Pack identification
  output logic pack_id_src_en,
  output logic [1:0] pack_id_level
);

  cpp_pkg::cpp_cmp_t cmp_meta;
  cpp_pkg::cpp_cmp_t cmp;
  logic [cpp_pkg::CTRL_W-1:0] ctrl;
  logic [2:0] evt;
  logic [$clog2(STARTUP_CYCLES+1)-1:0] boot_cnt;
  logic booting;
  cpp_pkg::cpp_phase_t st;
  cpp_pkg::cpp_phase_t next_st;
  logic allow_eff;
  logic run_eff;
  logic susp_eff;
  logic [1:0] rate;
  logic run_ok;
  logic input_ok;
  logic en_d;
  logic input_d;
  logic fin_d;
  logic restart_req;
  logic supplement;
  logic term_ok;
  logic start;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic [9:0] fast_ref;
  logic [2:0] evt_set;
  logic evt_clr;
  logic rise_req;
  logic [31:0] stat_word;

  // Comparators cross from the analog domain
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmp_meta <= '0;
      cmp <= '0;
    end
    else
    begin
      cmp_meta <= cmp_in;
      cmp <= cmp_meta;
    end
  end

  // APB decode; one wait state so read data comes from a flop
  assign mapped = (paddr == cpp_pkg::ADDR_CTRL) || (paddr == cpp_pkg::ADDR_STAT) ||
                  (paddr == cpp_pkg::ADDR_EVT);
  assign wr_en = psel && penable && pready && pwrite && mapped;
  assign rd_en = psel && penable && !pready;

  // Flags are the synced copies, so software sees what the sequencer acts on
  assign stat_word = {14'h0000, cmp, booting, st};

  // Every transfer, read or write, gets exactly one wait state
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= rd_en;
      pslverr <= rd_en && !mapped;
    end
  end

  // Read data is loaded in the first access cycle and held after it
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      prdata <= '0;
    else if (rd_en)
    begin
      case (paddr)
        cpp_pkg::ADDR_CTRL: prdata <= {21'h000000, ctrl};
        cpp_pkg::ADDR_STAT: prdata <= stat_word;
        cpp_pkg::ADDR_EVT: prdata <= {29'h00000000, evt};
        default: prdata <= '0;
      endcase
    end
  end

  // Control register; held bits keep their value through startup
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ctrl <= cpp_pkg::CTRL_RST;
    else if (wr_en && paddr == cpp_pkg::ADDR_CTRL)
      ctrl <= pwdata[cpp_pkg::CTRL_W-1:0];
  end

  // Event sources, one per sticky bit
  assign evt_set[cpp_pkg::E_REMOVED] = cmp.nobat;
  assign evt_set[cpp_pkg::E_TERM] = st == cpp_pkg::PH_REG && next_st == cpp_pkg::PH_DONE;
  assign evt_set[cpp_pkg::E_FAULT_SC] = cmp.out_short || cmp.bat_short;
  assign evt_clr = wr_en && paddr == cpp_pkg::ADDR_EVT;

  // Sticky events; a new event wins over a clear in the same cycle, so none is lost to software
  for (genvar i = 0; i < $bits(evt); i++)
  begin : g_evt
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
      if (!rst_n)
        evt[i] <= 1'b0;
      else if (evt_set[i])
        evt[i] <= 1'b1;
      else if (evt_clr && pwdata[i])
        evt[i] <= 1'b0;
    end
  end

  // Startup window after power-on
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      boot_cnt <= '0;
    else if (booting)
      boot_cnt <= boot_cnt + 1'b1;
  end
  assign booting = boot_cnt < STARTUP_CYCLES[$bits(boot_cnt)-1:0];

  // Startup overrides, released to the stored bits at the window's end
  assign allow_eff = booting ? 1'b1 : ctrl[cpp_pkg::B_ALLOW];
  assign run_eff = booting ? 1'b1 : ctrl[cpp_pkg::B_RUN];
  assign susp_eff = booting ? 1'b0 : ctrl[cpp_pkg::B_SUSP];
  assign rate = {ctrl[cpp_pkg::B_RATE_HI], ctrl[cpp_pkg::B_RATE_LO]};
  assign input_ok = cmp.ac_ok || cmp.usb_ok;
  assign run_ok = input_ok && allow_eff && run_eff && !susp_eff;

  // Level history for the restart edge detectors
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_d <= 1'b0;
      input_d <= 1'b0;
      fin_d <= 1'b0;
    end
    else
    begin
      en_d <= allow_eff && run_eff;
      input_d <= input_ok;
      fin_d <= ctrl[cpp_pkg::B_FIN_BLK];
    end
  end

  // Restart triggers: enable re-asserted or input re-inserted
  assign rise_req = (allow_eff && run_eff && !en_d) || (input_ok && !input_d);

  // A start consumes the request, even one raised by the edge that caused it;
  // a stale request would restart the cell right after termination
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      restart_req <= 1'b0;
    else if (start)
      restart_req <= 1'b0;
    else if (rise_req)
      restart_req <= 1'b1;
  end

  assign supplement = input_ok && allow_eff &&
                      (cmp.sup_need || (cmp.dppm_low && cmp.chg_zero));
  assign term_ok = cmp.taper && !cmp.hot && !cmp.dppm_low && !supplement &&
                   !ctrl[cpp_pkg::B_FIN_BLK];
  assign start = next_st == cpp_pkg::PH_PRE && (st == cpp_pkg::PH_IDLE || st == cpp_pkg::PH_DONE);

  // Phase sequencer
  always_comb
  begin
    next_st = st;
    if (!run_ok)
      next_st = cpp_pkg::PH_IDLE;
    else
    begin
      case (st)
        cpp_pkg::PH_IDLE:
          if (cmp.below_rch || restart_req)
            next_st = cpp_pkg::PH_PRE;
        cpp_pkg::PH_PRE:
          if (cmp.above_pre)
            next_st = cpp_pkg::PH_FAST;
        cpp_pkg::PH_FAST:
          if (cmp.cv_loop)
            next_st = cpp_pkg::PH_REG;
        cpp_pkg::PH_REG:
          if (term_ok)
            next_st = cpp_pkg::PH_DONE;
        cpp_pkg::PH_DONE:
          if (cmp.below_rch || restart_req || (ctrl[cpp_pkg::B_FIN_BLK] && !fin_d))
            next_st = cpp_pkg::PH_PRE;
        default:
          next_st = cpp_pkg::PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      st <= cpp_pkg::PH_IDLE;
    else
      st <= next_st;
  end

  // Rate scaling of the fast reference
  always_comb
  begin
    case (rate)
      2'h0: fast_ref = cpp_pkg::REF_25;
      2'h1: fast_ref = cpp_pkg::REF_50;
      2'h2: fast_ref = cpp_pkg::REF_75;
      default: fast_ref = cpp_pkg::REF_100;
    endcase
  end

  // Charger drive
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chg_enable <= 1'b0;
      chg_ref <= '0;
      term_ref <= '0;
      timer_start <= 1'b0;
      phase <= '0;
    end
    else
    begin
      chg_enable <= st == cpp_pkg::PH_PRE || st == cpp_pkg::PH_FAST || st == cpp_pkg::PH_REG;
      // Deep-discharge current is set by the resistor alone, not by the rate field
      chg_ref <= (cmp.lowv || st == cpp_pkg::PH_PRE) ? cpp_pkg::REF_PRE : fast_ref;
      term_ref <= fast_ref / cpp_pkg::TERM_DIV;
      timer_start <= start;
      phase <= st;
    end
  end

  // Thermal loop overrides the other loops; both only ever lower the current
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      thermal_fold <= 1'b0;
      chg_reduce <= 1'b0;
    end
    else
    begin
      thermal_fold <= cmp.hot;
      chg_reduce <= cmp.hot || cmp.dppm_low;
    end
  end

  // Power path selection and short-circuit handling
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sw <= '0;
      usb_limit <= cpp_pkg::LIM_100MA;
    end
    else
    begin
      sw.ac_on <= allow_eff && cmp.ac_ok && !cmp.out_short;
      sw.usb_on <= allow_eff && !cmp.ac_ok && cmp.usb_ok && !cmp.out_short;
      sw.bat_on <= !cmp.bat_short &&
                   (!allow_eff || !input_ok || supplement || chg_enable);
      sw.in_pullup <= cmp.out_short;
      sw.bat_pullup <= cmp.bat_short;
      sw.discharge <= cmp.nobat;
      if (booting || (!ctrl[cpp_pkg::B_LIM_WIDE] && !ctrl[cpp_pkg::B_LIM_HI]))
        usb_limit <= cpp_pkg::LIM_100MA;
      else if (ctrl[cpp_pkg::B_LIM_WIDE])
        usb_limit <= cpp_pkg::LIM_FULL;
      else
        usb_limit <= cpp_pkg::LIM_500MA;
    end
  end

  // Pack identification source
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pack_id_src_en <= 1'b0;
      pack_id_level <= '0;
    end
    else
    begin
      pack_id_src_en <= !ctrl[cpp_pkg::B_SLEEP];
      pack_id_level <= ctrl[cpp_pkg::B_ID_LO +: 2];
    end
  end

endmodule // cpp_ctrl

/* File: tb/cpp_ctrl_asserts.sv */
/*
  Port checker for cpp_ctrl, bound into it at the foot of this file.
  Assumes one clock domain and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module cpp_ctrl_asserts #(
  parameter int STARTUP_CYCLES = 1024
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Watched ports
  input wire cpp_pkg::cpp_cmp_t cmp_in,
  input wire cpp_pkg::cpp_sw_t sw,
  input wire logic [1:0] usb_limit,
  input wire logic chg_enable,
  input wire logic [9:0] chg_ref,
  input wire logic [9:0] term_ref,
  input wire logic thermal_fold,
  input wire logic chg_reduce,
  input wire logic timer_start,
  input wire logic [2:0] phase
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  int since_rst;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      since_rst <= 0;
    else if (since_rst < STARTUP_CYCLES)
      since_rst <= since_rst + 1;
  end
  boot_limit_a: assert property (since_rst < STARTUP_CYCLES |-> usb_limit == cpp_pkg::LIM_100MA)
    else $error("limit raised in startup");
  out_short_a: assert property (cmp_in.out_short [*5] |-> sw.in_pullup && !sw.ac_on && !sw.usb_on)
    else $error("inputs not isolated");
  bat_short_a: assert property (cmp_in.bat_short [*5] |-> sw.bat_pullup && !sw.bat_on)
    else $error("battery not isolated");
  pack_gone_a: assert property (cmp_in.nobat [*5] |-> sw.discharge)
    else $error("no discharge on removal");
  hot_fold_a: assert property (cmp_in.hot [*5] |-> thermal_fold && chg_reduce)
    else $error("no thermal foldback");
  deep_cut_a: assert property ((chg_enable && cmp_in.lowv) [*5] |-> chg_ref == cpp_pkg::REF_PRE)
    else $error("deep cell current high");
  term_ratio_a: assert property (chg_enable && chg_ref != cpp_pkg::REF_PRE |-> chg_ref == 10'(term_ref * 10))
    else $error("term ref not a tenth");
  timer_go_a: assert property (timer_start |=> !timer_start ##[0:3] phase == cpp_pkg::PH_PRE)
    else $error("timer start off cycle");
  done_from_a: assert property ($changed(phase) && phase == cpp_pkg::PH_DONE |-> $past(phase) == cpp_pkg::PH_REG)
    else $error("done not from regulate");
  cover property (timer_start);
  cover property (phase == cpp_pkg::PH_DONE);
  cover property (sw.in_pullup);
endmodule // cpp_ctrl_asserts
bind cpp_ctrl cpp_ctrl_asserts #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_cpp_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .cmp_in(cmp_in), .sw(sw), .usb_limit(usb_limit), .chg_enable(chg_enable), .chg_ref(chg_ref),
  .term_ref(term_ref), .thermal_fold(thermal_fold), .chg_reduce(chg_reduce), .timer_start(timer_start),
  .phase(phase));

/* File: tb/cpp_power_model.sv */
/*
  Pack and supply model producing the comparator flags.
  Assumes the bench sets pack voltage and external events.
*/
`timescale 1ns/1ps
module cpp_power_model #(
  parameter int LOWV_MV = 3000,
  parameter int RCH_MV = 4100,
  parameter int REG_MV = 4200
) (
  // Bench commands
  input wire cpp_pkg::cpp_cmp_t ext,
  input wire logic [12:0] bat_mv,
  // Flags to the controller
  output cpp_pkg::cpp_cmp_t cmp_in
);
  always_comb
  begin
    cmp_in = ext;
    cmp_in.lowv = int'(bat_mv) < LOWV_MV;
    cmp_in.above_pre = int'(bat_mv) >= LOWV_MV;
    cmp_in.below_rch = int'(bat_mv) < RCH_MV;
    cmp_in.cv_loop = int'(bat_mv) >= REG_MV;
    // Current tapers as soon as the voltage loop holds the cell
    cmp_in.taper = cmp_in.cv_loop;
  end
endmodule // cpp_power_model

/* File: tb/cpp_ctrl_tb.sv */
/*
  Self-checking bench for cpp_ctrl: APB tasks and flag scenarios.
  Assumes the power model supplies the comparator flags.
*/
`timescale 1ns/1ps
module cpp_ctrl_tb;
  logic clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, thermal_fold, chg_reduce, timer_start, chg_enable, pack_id_src_en;
  logic [12:0] bat_mv = 13'h0DAC, next_bat = 13'h0DAC;
  logic [9:0] chg_ref, term_ref;
  logic [9:0] fr [4] = '{cpp_pkg::REF_25, cpp_pkg::REF_50, cpp_pkg::REF_75, cpp_pkg::REF_100};
  logic [2:0] phase;
  logic [1:0] usb_limit, pack_id_level;
  cpp_pkg::cpp_cmp_t ext = 14'h2000, next_ext = 14'h2000, cmp_in;
  cpp_pkg::cpp_sw_t sw;
  int errors = 0, n_tests = 0, starts = 0;
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (timer_start === 1'b1)
      starts++;
  cpp_power_model pm (.ext(ext), .bat_mv(bat_mv), .cmp_in(cmp_in));
  cpp_ctrl #(.STARTUP_CYCLES(8)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_in(cmp_in), .sw(sw), .usb_limit(usb_limit), .chg_enable(chg_enable), .chg_ref(chg_ref),
    .term_ref(term_ref), .thermal_fold(thermal_fold), .chg_reduce(chg_reduce), .timer_start(timer_start),
    .phase(phase), .pack_id_src_en(pack_id_src_en), .pack_id_level(pack_id_level));
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic report_and_stop();
    if (errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Self-aligning: drives only just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
      @(posedge clk_sys);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] d);
    apb(1'b1, cpp_pkg::ADDR_CTRL, d);
    repeat (8) @(negedge clk_sys);
  endtask
  task automatic go();
    @(posedge clk_sys);
    ext <= next_ext;
    bat_mv <= next_bat;
    repeat (8) @(negedge clk_sys);
  endtask
  task automatic wph(input logic [2:0] p);
    for (int i = 0; i < 40 && phase !== p; i++)
      @(negedge clk_sys);
    chk("phase", 32'(phase), 32'(p));
  endtask
  initial
  begin
    #40000;
    errors++;
    report_and_stop();
  end
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    apb(1'b1, cpp_pkg::ADDR_CTRL, 32'h0000001B);
    repeat (2) @(negedge clk_sys);
    chk("usb_limit", 32'(usb_limit), 32'(cpp_pkg::LIM_100MA));
    chk("chg_enable", 32'(chg_enable), 32'h1);
    repeat (12) @(negedge clk_sys);
    chk("usb_limit", 32'(usb_limit), 32'(cpp_pkg::LIM_FULL));
    for (int i = 0; i < 3; i++)
    begin
      wr(32'h3 | 32'(i << 3));
      chk("usb_limit", 32'(usb_limit), 32'(i));
    end
    for (int r = 0; r < 4; r++)
    begin
      wr(32'h3 | 32'(r << 5));
      chk("chg_ref", 32'(chg_ref), 32'(fr[r]));
      chk("term_ref", 32'(term_ref), 32'(fr[r] / cpp_pkg::TERM_DIV));
    end
    wr(32'h2);
    chk("sw", {26'h0, sw}, 32'h8);
    next_bat = 13'h09C4;
    go();
    wr(32'h83);
    wph(cpp_pkg::PH_PRE);
    chk("chg_ref", 32'(chg_ref), 32'(cpp_pkg::REF_PRE));
    next_bat = 13'h1068;
    go();
    wph(cpp_pkg::PH_REG);
    next_ext.hot = 1'b1;
    go();
    wr(32'h3);
    chk("hot", {28'h0, phase, thermal_fold}, 32'h7);
    next_ext.hot = 1'b0;
    go();
    wph(cpp_pkg::PH_DONE);
    apb(1'b0, cpp_pkg::ADDR_EVT, 32'h0);
    chk("evt_term", 32'(q[cpp_pkg::E_TERM]), 32'h1);
    wr(32'h83);
    wph(cpp_pkg::PH_REG);
    wr(32'h3);
    wph(cpp_pkg::PH_DONE);
    next_bat = 13'h0FA0;
    go();
    wph(cpp_pkg::PH_FAST);
    next_ext.ac_ok = 1'b0;
    next_bat = 13'h1036;
    go();
    wph(cpp_pkg::PH_IDLE);
    next_ext.ac_ok = 1'b1;
    go();
    wph(cpp_pkg::PH_FAST);
    chk("starts", 32'(starts), 32'h5);
    next_ext.out_short = 1'b1;
    go();
    chk("sw_short", {30'h0, sw.ac_on, sw.in_pullup}, 32'h1);
    next_ext.out_short = 1'b0;
    next_ext.bat_short = 1'b1;
    go();
    chk("sw_bshort", {29'h0, sw.ac_on, sw.bat_on, sw.bat_pullup}, 32'h5);
    next_ext.bat_short = 1'b0;
    next_ext.nobat = 1'b1;
    go();
    chk("discharge", 32'(sw.discharge), 32'h1);
    apb(1'b0, cpp_pkg::ADDR_EVT, 32'h0);
    chk("evt_removed", 32'(q[cpp_pkg::E_REMOVED]), 32'h1);
    next_ext.nobat = 1'b0;
    next_ext.sup_need = 1'b1;
    go();
    wr(32'h7);
    chk("sup", 32'(sw.bat_on), 32'h1);
    next_ext.sup_need = 1'b0;
    next_ext.dppm_low = 1'b1;
    go();
    chk("dppm", {30'h0, chg_reduce, sw.bat_on}, 32'h2);
    next_ext.chg_zero = 1'b1;
    go();
    chk("dppm_zero", 32'(sw.bat_on), 32'h1);
    wr(32'h403);
    chk("pack_id", {29'h0, pack_id_src_en, pack_id_level}, 32'h6);
    wr(32'h503);
    chk("pack_id", {29'h0, pack_id_src_en, pack_id_level}, 32'h2);
    apb(1'b0, cpp_pkg::ADDR_STAT, 32'h0);
    chk("stat", q, 32'h00021880);
    apb(1'b0, 8'h0C, 32'h0);
    chk("bad_addr", {q[30:0], e}, 32'h1);
    next_ext.ac_ok = 1'b0;
    next_ext.usb_ok = 1'b1;
    go();
    chk("sw_usb", {30'h0, sw.ac_on, sw.usb_on}, 32'h1);
    report_and_stop();
  end
endmodule // cpp_ctrl_tb
